/* File: verilog/spc_pkg.sv */
package spc_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [11:0] OFF_GLOBAL_CTL = 12'h104;
    localparam logic [11:0] OFF_INT_STATUS = 12'h110;
    localparam logic [11:0] OFF_INT_ENABLE = 12'h114;
    localparam logic [11:0] OFF_COMMAND    = 12'h118;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_GIE   = 0;
    localparam int BIT_CPD   = 31;
    localparam int BIT_TFE   = 30;
    localparam int BIT_OVF   = 24;
    localparam int BIT_PRC   = 22;
    localparam int BIT_ILK   = 7;
    localparam int BIT_PCC   = 6;
    localparam int BIT_DPS   = 5;
    localparam int BIT_UFS   = 4;
    localparam int BIT_SDB   = 3;
    localparam int BIT_DSS   = 2;
    localparam int BIT_PSS   = 1;
    localparam int BIT_DHR   = 0;
    localparam int LSR_LSB   = 28;
    localparam int BIT_ASP   = 27;
    localparam int BIT_AGGRESSIVE_LINK_PM_ENABLE  = 26;
    localparam int BIT_LEDP  = 25;
    localparam int BIT_ATAPI = 24;
    localparam int BIT_ESP   = 21;

    // ------------------------------------------------------------
    // masks and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] IE_WMASK      = 32'h41c0_00ff;
    localparam logic [31:0] IS_W1C_MASK   = 32'h0100_00af;
    localparam logic [3:0]  CMD_PM_MASK   = 4'hf;
    localparam logic [31:0] INT_EN_RST    = 32'h0000_0000;
    localparam logic [31:0] INT_ST_RST    = 32'h0000_0000;
    localparam logic [3:0]  CMD_BITS_RST  = 4'h0;

    // ------------------------------------------------------------
    // link state request codes and link states
    // ------------------------------------------------------------
    localparam logic [3:0] LSR_NOP     = 4'h0;
    localparam logic [3:0] LSR_ACTIVE  = 4'h1;
    localparam logic [3:0] LSR_PARTIAL = 4'h2;
    localparam logic [3:0] LSR_SLUMBER = 4'h6;

    localparam logic [1:0] LS_ACTIVE  = 2'h1;
    localparam logic [1:0] LS_PARTIAL = 2'h2;
    localparam logic [1:0] LS_SLUMBER = 2'h3;

    typedef enum logic [0:0] {
        LSM_IDLE = 1'b0,
        LSM_WAIT = 1'b1
    } spc_lsm_t;

endpackage : spc_pkg

/* File: verilog/spc_port_ctl.sv */
//
// Contract
// - overflow sets w1c status bit 24
// - bit 22 mirrors diag phy ready change
// - interlock toggle sets bit 7, else zero
// - bit 6 mirrors diag exchange
// - flagged descriptor done sets bit 5
// - bit 4 set on post, cleared by diag
// - set-bits, dma-setup, d2h frames set bits 3,2,0
// - pio setup bit after frame and data
// - interrupt needs enable; status records regardless
// - taskfile error interrupt needs enable and global
// - interlock interrupt ignores global enable
// - unknown frame interrupt needs both enables
// - cold presence enable reads zero
// - request codes 6,2,1,0; others reserved
// - action done then field returns to 0
// - same-state request just returns to idle
// - refused request leaves link as is
// - aggressive pm enters slumber or partial
// - led on packet commands when enabled
// - atapi marking steers activity led
// - external port write-once, survives function reset
//
// The APB register port was chosen for this implementation.
module spc_port_ctl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        func_level_reset,
    input  wire logic        overflow_evt,
    input  wire logic        descriptor_done_evt,
    input  wire logic        set_bits_frame_evt,
    input  wire logic        dma_setup_frame_evt,
    input  wire logic        d2h_register_frame_evt,
    input  wire logic        pio_setup_copied_evt,
    input  wire logic        pio_data_done_evt,
    input  wire logic        unknown_frame_posted_evt,
    input  wire logic        diag_phy_ready_change,
    input  wire logic        diag_exchange,
    input  wire logic        diag_unknown_frame,
    input  wire logic        taskfile_status_error,
    input  wire logic        interlock_switch_pin,
    input  wire logic        interlock_support_cap,
    input  wire logic        external_support_cap,
    input  wire logic        cmd_issue_empty,
    input  wire logic        sata_active_empty,
    input  wire logic        cmd_active,
    input  wire logic [1:0]  cur_link_state,
    input  wire logic        link_done,
    input  wire logic        link_reject,
    output logic             port_irq,
    output logic             activity_led,
    output logic             link_req,
    output logic      [1:0]  link_req_state
);

    // --------------------
    // pin synchronisers
    // --------------------
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic       ilk_last;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1    <= 3'h0;
            sync2    <= 3'h0;
            ilk_last <= 1'b0;
        end
        else
        begin
            sync1    <= {external_support_cap, interlock_support_cap, interlock_switch_pin};
            sync2    <= sync1;
            ilk_last <= sync2[0];
        end
    end

    wire ilk_cap   = sync2[1];
    wire ext_cap   = sync2[2];
    wire ilk_event = ilk_cap & (sync2[0] ^ ilk_last);

    // --------------------
    // apb decode
    // --------------------
    logic [31:0] int_enable;
    logic [31:0] int_status;
    logic        global_int_enable;
    logic        prc_q;
    logic        pcc_q;
    logic        ufs_q;
    logic        pio_pending;
    logic [3:0]  lsr;
    logic [3:0]  pm_bits;
    logic        external_port_flag;
    logic        esp_locked;
    spc_pkg::spc_lsm_t lsm;

    // one wait state: pready rises the cycle after the access phase begins
    wire acc     = psel & penable & ~pready;
    wire xfer    = psel & penable & pready;
    wire wr      = xfer & pwrite;
    wire hit_gc  = (paddr == spc_pkg::OFF_GLOBAL_CTL);
    wire hit_is  = (paddr == spc_pkg::OFF_INT_STATUS);
    wire hit_ie  = (paddr == spc_pkg::OFF_INT_ENABLE);
    wire hit_cmd = (paddr == spc_pkg::OFF_COMMAND);
    wire mapped  = hit_gc | hit_is | hit_ie | hit_cmd;
    wire wr_gc   = wr & hit_gc;
    wire wr_is   = wr & hit_is;
    wire wr_ie   = wr & hit_ie;
    wire wr_cmd  = wr & hit_cmd;

    // --------------------
    // status view
    // --------------------
    wire [31:0] mirror_bits = ({31'h0, prc_q} << spc_pkg::BIT_PRC)
                            | ({31'h0, pcc_q} << spc_pkg::BIT_PCC)
                            | ({31'h0, ufs_q} << spc_pkg::BIT_UFS);
    wire [31:0] status_view = int_status | mirror_bits;

    wire [31:0] ie_wmask = ilk_cap ? spc_pkg::IE_WMASK
                                   : (spc_pkg::IE_WMASK & ~(32'h1 << spc_pkg::BIT_ILK));

    wire [31:0] cmd_view = ({28'h0, lsr} << spc_pkg::LSR_LSB)
                         | ({28'h0, pm_bits} << spc_pkg::BIT_ATAPI)
                         | ({31'h0, external_port_flag} << spc_pkg::BIT_ESP);

    wire [31:0] rd_mux = hit_gc ? {31'h0, global_int_enable}
                       : hit_is ? status_view
                       : hit_ie ? int_enable
                       : hit_cmd ? cmd_view
                       : 32'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end
        else
        begin
            pready  <= acc;
            pslverr <= acc & ~mapped;
            prdata  <= acc ? rd_mux : 32'h0;
        end
    end

    // --------------------
    // enables and global enable
    // --------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_enable        <= spc_pkg::INT_EN_RST;
            global_int_enable <= 1'b0;
        end
        else if (func_level_reset)
        begin
            int_enable        <= spc_pkg::INT_EN_RST;
            global_int_enable <= 1'b0;
        end
        else
        begin
            if (wr_ie)
                int_enable <= pwdata & ie_wmask;
            if (wr_gc)
                global_int_enable <= pwdata[spc_pkg::BIT_GIE];
        end
    end

    // --------------------
    // sticky status
    // --------------------
    wire pss_set = pio_data_done_evt & (pio_pending | pio_setup_copied_evt);

    wire [31:0] set_vec = ({31'h0, overflow_evt} << spc_pkg::BIT_OVF)
                        | ({31'h0, ilk_event} << spc_pkg::BIT_ILK)
                        | ({31'h0, descriptor_done_evt} << spc_pkg::BIT_DPS)
                        | ({31'h0, set_bits_frame_evt} << spc_pkg::BIT_SDB)
                        | ({31'h0, dma_setup_frame_evt} << spc_pkg::BIT_DSS)
                        | ({31'h0, pss_set} << spc_pkg::BIT_PSS)
                        | ({31'h0, d2h_register_frame_evt} << spc_pkg::BIT_DHR);
    wire [31:0] clr_vec = wr_is ? (pwdata & spc_pkg::IS_W1C_MASK) : 32'h0;

    // set wins over a clear in the same cycle; bit 7 held low without interlock
    wire [31:0] ilk_keep = ilk_cap ? 32'hffff_ffff : ~(32'h1 << spc_pkg::BIT_ILK);
    wire [31:0] next_status = ((int_status & ~clr_vec) | set_vec) & ilk_keep;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_status  <= spc_pkg::INT_ST_RST;
            pio_pending <= 1'b0;
        end
        else if (func_level_reset)
        begin
            int_status  <= spc_pkg::INT_ST_RST;
            pio_pending <= 1'b0;
        end
        else
        begin
            int_status  <= next_status;
            pio_pending <= (pio_pending | pio_setup_copied_evt) & ~pio_data_done_evt;
        end
    end

    // mirrors follow the diagnostic bits; unknown frame waits for the post
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prc_q <= 1'b0;
            pcc_q <= 1'b0;
            ufs_q <= 1'b0;
        end
        else
        begin
            prc_q <= diag_phy_ready_change;
            pcc_q <= diag_exchange;
            ufs_q <= diag_unknown_frame & (ufs_q | unknown_frame_posted_evt);
        end
    end

    // --------------------
    // interrupt request
    // --------------------
    wire [31:0] gated_src = status_view & int_enable & ~(32'h1 << spc_pkg::BIT_ILK);
    wire tfe_term  = int_enable[spc_pkg::BIT_TFE] & taskfile_status_error;
    wire ilk_term  = int_enable[spc_pkg::BIT_ILK] & int_status[spc_pkg::BIT_ILK];
    wire next_irq  = (global_int_enable & ((|gated_src) | tfe_term)) | ilk_term;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            port_irq <= 1'b0;
        else
            port_irq <= next_irq;
    end

    // --------------------
    // command register
    // --------------------
    wire [3:0] wr_lsr    = pwdata[spc_pkg::LSR_LSB +: 4];
    wire       lsr_legal = (wr_lsr == spc_pkg::LSR_ACTIVE) | (wr_lsr == spc_pkg::LSR_PARTIAL)
                         | (wr_lsr == spc_pkg::LSR_SLUMBER);
    // a new code is only taken while the field reads idle
    wire       lsr_load  = wr_cmd & lsr_legal & (lsr == spc_pkg::LSR_NOP);
    logic      lsr_clear;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lsr     <= spc_pkg::LSR_NOP;
            pm_bits <= spc_pkg::CMD_BITS_RST;
        end
        else if (func_level_reset)
        begin
            lsr     <= spc_pkg::LSR_NOP;
            pm_bits <= spc_pkg::CMD_BITS_RST;
        end
        else
        begin
            if (lsr_clear)
                lsr <= spc_pkg::LSR_NOP;
            else if (lsr_load)
                lsr <= wr_lsr;
            if (wr_cmd)
                pm_bits <= pwdata[spc_pkg::BIT_ATAPI +: 4] & spc_pkg::CMD_PM_MASK;
        end
    end

    // not touched by function level reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            external_port_flag <= 1'b0;
            esp_locked         <= 1'b0;
        end
        else if (wr_cmd && !esp_locked)
        begin
            external_port_flag <= pwdata[spc_pkg::BIT_ESP] & ext_cap;
            esp_locked         <= 1'b1;
        end
    end

    wire aggressive_deep_select   = pm_bits[spc_pkg::BIT_ASP - spc_pkg::BIT_ATAPI];
    wire aggressive_link_pm_enable  = pm_bits[spc_pkg::BIT_AGGRESSIVE_LINK_PM_ENABLE - spc_pkg::BIT_ATAPI];
    wire ledp  = pm_bits[spc_pkg::BIT_LEDP - spc_pkg::BIT_ATAPI];
    wire atapi = pm_bits[0];

    // --------------------
    // link power sequencer
    // --------------------
    logic idle_last;
    wire  cmds_idle  = cmd_issue_empty & sata_active_empty;
    wire  idle_rise  = cmds_idle & ~idle_last;
    wire [1:0] lsr_target = (lsr == spc_pkg::LSR_SLUMBER) ? spc_pkg::LS_SLUMBER
                          : (lsr == spc_pkg::LSR_PARTIAL) ? spc_pkg::LS_PARTIAL
                          : spc_pkg::LS_ACTIVE;
    wire [1:0] aggr_target = aggressive_deep_select ? spc_pkg::LS_SLUMBER : spc_pkg::LS_PARTIAL;
    wire  sw_req     = (lsm == spc_pkg::LSM_IDLE) & (lsr != spc_pkg::LSR_NOP);
    wire  same_state = sw_req & (lsr_target == cur_link_state);
    wire  aggr_req   = (lsm == spc_pkg::LSM_IDLE) & (lsr == spc_pkg::LSR_NOP) & aggressive_link_pm_enable & idle_rise
                     & (cur_link_state == spc_pkg::LS_ACTIVE);
    wire  wait_end   = (lsm == spc_pkg::LSM_WAIT) & (link_done | link_reject);
    spc_pkg::spc_lsm_t next_lsm;

    assign lsr_clear = same_state | wait_end;

    always_comb
    begin
        next_lsm = lsm;
        unique case (lsm)
            spc_pkg::LSM_IDLE:
                if ((sw_req && !same_state) || aggr_req)
                    next_lsm = spc_pkg::LSM_WAIT;
            spc_pkg::LSM_WAIT:
                if (link_done || link_reject)
                    next_lsm = spc_pkg::LSM_IDLE;
        endcase
    end

    // a refusal needs no undo: the request is just withdrawn
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lsm            <= spc_pkg::LSM_IDLE;
            link_req       <= 1'b0;
            link_req_state <= spc_pkg::LS_ACTIVE;
            idle_last      <= 1'b0;
        end
        else
        begin
            lsm       <= next_lsm;
            idle_last <= cmds_idle;
            if (lsm == spc_pkg::LSM_IDLE && next_lsm == spc_pkg::LSM_WAIT)
            begin
                link_req       <= 1'b1;
                link_req_state <= sw_req ? lsr_target : aggr_target;
            end
            else if (wait_end)
                link_req <= 1'b0;
        end
    end

    // --------------------
    // activity led
    // --------------------
    wire next_led = cmd_active & (~atapi | ledp);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            activity_led <= 1'b0;
        else
            activity_led <= next_led;
    end

    // --------------------
    // assertions
    // --------------------
    sequence s_same_req;
        wr_cmd && lsr_load && lsm == spc_pkg::LSM_IDLE;
    endsequence

    sequence s_back_idle;
        lsr == spc_pkg::LSR_NOP && !link_req;
    endsequence

    property p_ovf_set;
        @(posedge pclk) disable iff (!presetn)
        overflow_evt && !func_level_reset |=> int_status[spc_pkg::BIT_OVF];
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow not latched");

    property p_prc_mirror;
        @(posedge pclk) disable iff (!presetn)
        ##1 status_view[spc_pkg::BIT_PRC] == $past(diag_phy_ready_change);
    endproperty
    a_prc_mirror: assert property (p_prc_mirror) else $error("phy ready mirror wrong");

    property p_ilk_zero;
        @(posedge pclk) disable iff (!presetn)
        !ilk_cap |=> !int_status[spc_pkg::BIT_ILK];
    endproperty
    a_ilk_zero: assert property (p_ilk_zero) else $error("interlock bit without support");

    property p_w1c_clear;
        @(posedge pclk) disable iff (!presetn)
        wr_is && pwdata[spc_pkg::BIT_DPS] && !descriptor_done_evt |=> !int_status[spc_pkg::BIT_DPS];
    endproperty
    a_w1c_clear: assert property (p_w1c_clear) else $error("w1c clear failed");

    property p_tfe_irq;
        @(posedge pclk) disable iff (!presetn)
        global_int_enable && int_enable[spc_pkg::BIT_TFE] && taskfile_status_error |=> port_irq;
    endproperty
    a_tfe_irq: assert property (p_tfe_irq) else $error("taskfile irq missing");

    property p_ilk_irq;
        @(posedge pclk) disable iff (!presetn)
        int_enable[spc_pkg::BIT_ILK] && int_status[spc_pkg::BIT_ILK] |=> port_irq;
    endproperty
    a_ilk_irq: assert property (p_ilk_irq) else $error("interlock irq missing");

    property p_no_irq;
        @(posedge pclk) disable iff (!presetn)
        !global_int_enable && !ilk_term |=> !port_irq;
    endproperty
    a_no_irq: assert property (p_no_irq) else $error("irq without enable");

    property p_same_state;
        @(posedge pclk) disable iff (!presetn)
        s_same_req ##1 (lsr_target == cur_link_state && lsm == spc_pkg::LSM_IDLE) |=> s_back_idle;
    endproperty
    a_same_state: assert property (p_same_state) else $error("same state not idled");

    property p_reject;
        @(posedge pclk) disable iff (!presetn)
        lsm == spc_pkg::LSM_WAIT && link_reject |=> s_back_idle ##1 lsm == spc_pkg::LSM_IDLE;
    endproperty
    a_reject: assert property (p_reject) else $error("reject not handled");

    property p_aggr;
        @(posedge pclk) disable iff (!presetn)
        aggr_req |=> link_req && link_req_state == (aggressive_deep_select ? spc_pkg::LS_SLUMBER : spc_pkg::LS_PARTIAL);
    endproperty
    a_aggr: assert property (p_aggr) else $error("aggressive pm wrong target");

    property p_led;
        @(posedge pclk) disable iff (!presetn)
        cmd_active && atapi && !ledp |=> !activity_led;
    endproperty
    a_led: assert property (p_led) else $error("led lit for packet command");

    property p_esp_once;
        @(posedge pclk) disable iff (!presetn)
        esp_locked |=> $stable(external_port_flag);
    endproperty
    a_esp_once: assert property (p_esp_once) else $error("external flag rewritten");

endmodule : spc_port_ctl

/* File: tb/spc_dev_model.sv */
module spc_dev_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       link_req,
    input  wire logic [1:0] link_req_state,
    input  wire logic       refuse,
    input  wire logic       slow,
    output logic      [1:0] cur_link_state,
    output logic            link_done,
    output logic            link_reject
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // link partner: answers after 1 or 8 cycles
    // ----------------------------------------
    logic [3:0] wait_cnt;
    wire        busy   = link_done | link_reject;
    wire        answer = link_req & ~busy & (wait_cnt == (slow ? 4'h8 : 4'h1));
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wait_cnt       <= 4'h0;
            cur_link_state <= spc_pkg::LS_ACTIVE;
            link_done      <= 1'b0;
            link_reject    <= 1'b0;
        end
        else
        begin
            wait_cnt    <= (link_req & ~busy & ~answer) ? wait_cnt + 4'h1 : 4'h0;
            link_done   <= answer & ~refuse;
            // refused request keeps the present state
            link_reject <= answer & refuse;
            if (answer & ~refuse)
                cur_link_state <= link_req_state;
        end
    end
endmodule : spc_dev_model

/* File: tb/spc_port_ctl_tb.sv */
module spc_port_ctl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, req_d = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, q, prdata;
    logic [7:0]  ev = 8'h00;
    logic        flr = 1'b0, d_prc = 1'b0, d_x = 1'b0, d_uf = 1'b0, tfe = 1'b0, ilk = 1'b0, ilk_cap = 1'b0;
    logic        ext_cap = 1'b1, q_empty = 1'b0, cact = 1'b0, refuse = 1'b0, slow = 1'b0;
    logic        pready, pslverr, port_irq, activity_led, link_req, link_done, link_reject;
    logic [1:0]  link_req_state, cur_link_state;
    int          mismatches = 0, n_tests = 0, req_n = 0;
    localparam logic [31:0] SB [5] = '{32'h0100_0000, 32'h20, 32'h8, 32'h4, 32'h1};
    localparam logic [3:0]  LC [5] = '{4'h6, 4'h6, 4'h2, 4'h1, 4'h3};
    localparam logic [31:0] LX [5] = '{32'h3, 32'h3, 32'h3, 32'h1, 32'h1};
    localparam logic [31:0] LR [5] = '{32'h1, 32'h0, 32'h1, 32'h1, 32'h0};
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        req_n += int'(link_req & ~req_d);
        req_d = link_req;
    end
    spc_port_ctl dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .func_level_reset(flr), .overflow_evt(ev[0]), .descriptor_done_evt(ev[1]), .set_bits_frame_evt(ev[2]),
        .dma_setup_frame_evt(ev[3]), .d2h_register_frame_evt(ev[4]), .pio_setup_copied_evt(ev[5]),
        .pio_data_done_evt(ev[6]), .unknown_frame_posted_evt(ev[7]), .diag_phy_ready_change(d_prc),
        .diag_exchange(d_x), .diag_unknown_frame(d_uf), .taskfile_status_error(tfe),
        .interlock_switch_pin(ilk), .interlock_support_cap(ilk_cap), .external_support_cap(ext_cap),
        .cmd_issue_empty(q_empty), .sata_active_empty(q_empty), .cmd_active(cact),
        .cur_link_state(cur_link_state), .link_done(link_done), .link_reject(link_reject),
        .port_irq(port_irq), .activity_led(activity_led), .link_req(link_req), .link_req_state(link_req_state));
    spc_dev_model partner (.pclk(pclk), .presetn(presetn), .link_req(link_req), .link_req_state(link_req_state),
        .refuse(refuse), .slow(slow), .cur_link_state(cur_link_state), .link_done(link_done),
        .link_reject(link_reject));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask : tick
    // request held until pready is seen high at an edge
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int n;
        paddr  <= a;
        pwrite <= w;
        pwdata <= d;
        psel   <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 16)
        begin
            @(posedge pclk);
            n++;
        end
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n == 16)
        begin
            mismatches++;
            summarize();
        end
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        apb(a, 1'b0, 32'h0);
    endtask : rd
    task automatic pulse(input logic [7:0] m);
        ev <= m;
        @(posedge pclk);
        ev <= 8'h00;
        @(posedge pclk);
    endtask : pulse
    task automatic wait_idle();
        q = 32'hf000_0000;
        for (int n = 0; n < 40 && q[31:28] !== 4'h0; n++)
            rd(spc_pkg::OFF_COMMAND);
        if (q[31:28] !== 4'h0)
        begin
            mismatches++;
            summarize();
        end
    endtask : wait_idle
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial
    begin
        logic [31:0] exp;
        int          k;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        tick(3);
        rd(spc_pkg::OFF_INT_ENABLE);
        check(q, 32'h0);
        rd(12'h11c);
        check({err, q[30:0]}, 32'h8000_0000);
        wr(spc_pkg::OFF_COMMAND, 32'h0020_0000);
        wr(spc_pkg::OFF_COMMAND, 32'h0);
        wr(spc_pkg::OFF_INT_ENABLE, 32'hffff_ffff);
        rd(spc_pkg::OFF_INT_ENABLE);
        check(q, 32'h41c0_007f);
        flr <= 1'b1;
        tick(1);
        flr <= 1'b0;
        rd(spc_pkg::OFF_INT_ENABLE);
        check(q, 32'h0);
        rd(spc_pkg::OFF_COMMAND);
        check(q & 32'hff20_0000, 32'h0020_0000);
        $display("test reset_and_external done");
        wr(spc_pkg::OFF_INT_ENABLE, 32'hffff_ffff);
        exp = 32'h0;
        for (int i = 0; i < 5; i++)
        begin
            pulse(8'h01 << i);
            exp |= SB[i];
            rd(spc_pkg::OFF_INT_STATUS);
            check(q, exp);
        end
        check({31'h0, port_irq}, 32'h0);
        wr(spc_pkg::OFF_INT_STATUS, 32'h0);
        rd(spc_pkg::OFF_INT_STATUS);
        check(q, exp);
        wr(spc_pkg::OFF_GLOBAL_CTL, 32'h1);
        tick(2);
        check({31'h0, port_irq}, 32'h1);
        wr(spc_pkg::OFF_INT_STATUS, exp);
        tick(2);
        check({31'h0, port_irq}, 32'h0);
        rd(spc_pkg::OFF_INT_STATUS);
        check(q, 32'h0);
        $display("test frame_events done");
        d_prc <= 1'b1;
        d_x <= 1'b1;
        tick(2);
        wr(spc_pkg::OFF_INT_STATUS, 32'h0040_0040);
        rd(spc_pkg::OFF_INT_STATUS);
        check(q, 32'h0040_0040);
        check({31'h0, port_irq}, 32'h1);
        d_prc <= 1'b0;
        d_x <= 1'b0;
        d_uf <= 1'b1;
        tick(2);
        rd(spc_pkg::OFF_INT_STATUS);
        check(q, 32'h0);
        check({31'h0, port_irq}, 32'h0);
        pulse(8'h80);
        tick(1);
        check({31'h0, port_irq}, 32'h1);
        rd(spc_pkg::OFF_INT_STATUS);
        check(q, 32'h10);
        d_uf <= 1'b0;
        tick(2);
        pulse(8'h20);
        rd(spc_pkg::OFF_INT_STATUS);
        check(q, 32'h0);
        pulse(8'h40);
        rd(spc_pkg::OFF_INT_STATUS);
        check(q, 32'h2);
        wr(spc_pkg::OFF_INT_STATUS, 32'h2);
        tfe <= 1'b1;
        tick(3);
        check({31'h0, port_irq}, 32'h1);
        wr(spc_pkg::OFF_GLOBAL_CTL, 32'h0);
        tick(2);
        check({31'h0, port_irq}, 32'h0);
        tfe <= 1'b0;
        $display("test mirrors_and_gating done");
        ilk <= 1'b1;
        tick(4);
        rd(spc_pkg::OFF_INT_STATUS);
        check(q, 32'h0);
        ilk_cap <= 1'b1;
        tick(3);
        wr(spc_pkg::OFF_INT_ENABLE, 32'h80);
        rd(spc_pkg::OFF_INT_ENABLE);
        check(q, 32'h80);
        ilk <= 1'b0;
        tick(4);
        rd(spc_pkg::OFF_INT_STATUS);
        check(q, 32'h80);
        check({31'h0, port_irq}, 32'h1);
        $display("test interlock done");
        // no low-power code is written while aggressive pm is on
        for (int i = 0; i < 5; i++)
        begin
            k = req_n;
            refuse <= (i == 2);
            slow <= (i == 0);
            wr(spc_pkg::OFF_COMMAND, {LC[i], 28'h0});
            wait_idle();
            check({30'h0, cur_link_state}, LX[i]);
            check(32'(req_n - k), LR[i]);
        end
        wr(spc_pkg::OFF_COMMAND, 32'h0400_0000);
        q_empty <= 1'b1;
        tick(12);
        check({30'h0, cur_link_state}, {30'h0, spc_pkg::LS_PARTIAL});
        $display("test link_requests done");
        cact <= 1'b1;
        for (int i = 0; i < 3; i++)
        begin
            wr(spc_pkg::OFF_COMMAND, {8'(i == 0 ? 8'h01 : (i == 1 ? 8'h03 : 8'h00)), 24'h0});
            tick(2);
            check({31'h0, activity_led}, (i == 0) ? 32'h0 : 32'h1);
        end
        $display("test activity_led done");
        summarize();
    end
endmodule : spc_port_ctl_tb
